/* File: bsc_pkg.sv */
// Constants and types for the sensorless commutation sequencer
package bsc_pkg;
  localparam int          BSC_TW          = 16;
  localparam int          BSC_VW          = 12;
  localparam real         BSC_CLK_MHZ     = 200.0;
  localparam real         BSC_TICK_MS     = 1.0;
  localparam int unsigned BSC_TICK_CYC    =
    int'(BSC_TICK_MS * 1000.0 * BSC_CLK_MHZ);
  localparam logic [2:0]  BSC_SECTOR_LAST = 3'h5;
  localparam logic [2:0]  BSC_SECTOR_RST  = 3'h0;
  // Sector applied first after alignment: 90 degrees ahead of rotor flux
  localparam logic [2:0]  BSC_SECTOR_START = 3'h1;
  localparam logic [15:0] BSC_ALIGN_DEF   = 16'h1000;
  localparam logic [7:0]  BSC_OPEN_DEF    = 8'h10;
  localparam logic [15:0] BSC_BLANK_DEF   = 16'h0040;
  localparam logic [15:0] BSC_ADV_DEF     = 16'h0000;
  localparam int          BSC_FILT_SHIFT  = 2;
  // Avalon register offsets (byte addresses)
  localparam logic [5:0]  BSC_REG_CTRL    = 6'h00;
  localparam logic [5:0]  BSC_REG_ALIGN   = 6'h04;
  localparam logic [5:0]  BSC_REG_OPEN    = 6'h08;
  localparam logic [5:0]  BSC_REG_BLANK   = 6'h0c;
  localparam logic [5:0]  BSC_REG_ADV     = 6'h10;
  localparam logic [5:0]  BSC_REG_DUTY    = 6'h14;
  localparam logic [5:0]  BSC_REG_OLPER   = 6'h18;
  localparam logic [5:0]  BSC_REG_STATUS  = 6'h1c;
  localparam logic [5:0]  BSC_REG_ZCPER   = 6'h20;
  localparam logic [5:0]  BSC_REG_NEXTC   = 6'h24;
  localparam logic [15:0] BSC_OLPER_DEF   = 16'h2000;
  typedef enum logic [1:0] {
    BSC_IDLE, BSC_ALIGN, BSC_OPEN, BSC_RUN
  } bsc_state_t;
endpackage

/* File: bsc_seq.sv */
// Sensorless six-step commutation sequencer with Avalon-MM registers
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R1: Alignment, open-loop and run states; closed loop only in run.
// R2: Alignment drives A and B with regulator duty, C at zero.
// R3: Alignment timeout moves the sequencer to open-loop start.
// R4: First open-loop vector leads aligned rotor flux by 90 degrees.
// R5: After set open-loop commutations enter run, timed by crossings.
// R6: On trigger done, back up old timestamp and capture timer.
// R7: Crossing processing starts only when both converter lists finish.
// R8: Back-EMF equals phase voltage minus half bus voltage, signed.
// R9: No evaluation while commutation blanking interval still runs.
// R10: No evaluation after a crossing found or in open loop.
// R11: Sector 0 to 5 selects detector behaviour.
// R12: Current back-EMF saved as previous after every evaluation.
// R13: On a crossing, select next sensed phase on the mux.
// R14: After mux update, raise global load-ok for trigger unit.
// R15: Sensed phase and sector choose rising or falling detection.
// R16: Rising: negative back-EMF means not yet crossed, no update.
// R17: Positive: offset is bemf over sample delta times period.
// R18: Keep old and new crossing times, filter their difference.
// R19: Next commutation is crossing plus half period minus advance.
// R20: After scheduling, mark crossing found for this period.
// R21: Commutation fires from timer compare match.
// R22: Speed-control tick raised every millisecond.
// R23: Falling detection negates back-EMF before the rising test.
// R24: Commutation clears found flag, restarts blanking, sector mod 6.
module bsc_seq import bsc_pkg::*; #(
  parameter int unsigned TICK_CYC = BSC_TICK_CYC
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                init_done,
  input  wire logic [BSC_TW-1:0]   timer_value,
  input  wire logic                trigger_done,
  input  wire logic                adc0_done,
  input  wire logic                adc1_done,
  input  wire logic [BSC_VW-1:0]   phase_voltage,
  input  wire logic [BSC_VW-1:0]   bus_voltage,
  output logic [2:0]               sector,
  output logic [1:0]               phase_mux,
  output logic                     glb_ldok,
  output logic                     commutate,
  output logic                     speed_tick,
  output logic [1:0]               run_state,
  output logic                     align_drive,
  output logic [15:0]              align_duty_a,
  output logic [15:0]              align_duty_b,
  output logic [15:0]              align_duty_c
);
  ////////////////////////////////////////////////////////////////////////
  // Registers and bus
  logic        enable_q;
  logic [15:0] align_len_q, blank_len_q, adv_q, duty_q, olper_q;
  logic [7:0]  open_cnt_q;
  logic        bus_ack_q;
  bsc_state_t  state_q;
  logic        found_q;
  logic [15:0] zc_per_q, next_comm_q;

  // Sensed phase is the floating one of the sector
  function automatic logic [1:0] float_phase(input logic [2:0] s);
    case (s)
      3'h0, 3'h3: float_phase = 2'h2;
      3'h1, 3'h4: float_phase = 2'h1;
      default:    float_phase = 2'h0;
    endcase
  endfunction

  // Wraps by compare: six sectors do not fit a power-of-two counter
  function automatic logic [2:0] sector_inc(input logic [2:0] s);
    sector_inc = (s == BSC_SECTOR_LAST) ? 3'h0 : s + 3'h1;
  endfunction

  // One wait state gives the read mux a full cycle; waitrequest is
  // its own flop so the bus never sees a gated level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_ack_q       <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      bus_ack_q       <= (avs_read | avs_write) & ~bus_ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~bus_ack_q);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_q    <= 1'b0;
      align_len_q <= BSC_ALIGN_DEF;
      open_cnt_q  <= BSC_OPEN_DEF;
      blank_len_q <= BSC_BLANK_DEF;
      adv_q       <= BSC_ADV_DEF;
      duty_q      <= 16'h0000;
      olper_q     <= BSC_OLPER_DEF;
    end else if (avs_write & bus_ack_q) begin
      if (avs_address == BSC_REG_CTRL) begin
        enable_q <= avs_writedata[0];
      end else if (avs_address == BSC_REG_ALIGN) begin
        align_len_q <= avs_writedata[15:0];
      end else if (avs_address == BSC_REG_OPEN) begin
        open_cnt_q <= avs_writedata[7:0];
      end else if (avs_address == BSC_REG_BLANK) begin
        blank_len_q <= avs_writedata[15:0];
      end else if (avs_address == BSC_REG_ADV) begin
        adv_q <= avs_writedata[15:0];
      end else if (avs_address == BSC_REG_DUTY) begin
        duty_q <= avs_writedata[15:0];
      end else if (avs_address == BSC_REG_OLPER) begin
        olper_q <= avs_writedata[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~bus_ack_q) begin
      // Loaded on the request edge, stands through the acknowledge edge
      if (avs_address == BSC_REG_CTRL) begin
        avs_readdata <= {31'h0, enable_q};
      end else if (avs_address == BSC_REG_ALIGN) begin
        avs_readdata <= {16'h0, align_len_q};
      end else if (avs_address == BSC_REG_OPEN) begin
        avs_readdata <= {24'h0, open_cnt_q};
      end else if (avs_address == BSC_REG_BLANK) begin
        avs_readdata <= {16'h0, blank_len_q};
      end else if (avs_address == BSC_REG_ADV) begin
        avs_readdata <= {16'h0, adv_q};
      end else if (avs_address == BSC_REG_DUTY) begin
        avs_readdata <= {16'h0, duty_q};
      end else if (avs_address == BSC_REG_OLPER) begin
        avs_readdata <= {16'h0, olper_q};
      end else if (avs_address == BSC_REG_STATUS) begin
        avs_readdata <= {24'h0, found_q, sector, phase_mux, state_q};
      end else if (avs_address == BSC_REG_ZCPER) begin
        avs_readdata <= {16'h0, zc_per_q};
      end else if (avs_address == BSC_REG_NEXTC) begin
        avs_readdata <= {16'h0, next_comm_q};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Top-level sequencer
  logic [15:0] seq_cnt_q;
  logic [7:0]  comm_cnt_q;
  logic        comm_ev;
  logic        run_comm_hit, ol_comm_hit;

  // Exact compare: a time already passed waits for the timer to wrap
  assign ol_comm_hit  = (state_q == BSC_OPEN) && (seq_cnt_q == olper_q);
  assign run_comm_hit = (state_q == BSC_RUN) && found_q
                        && (timer_value == next_comm_q);          // R21
  assign comm_ev      = ol_comm_hit | run_comm_hit;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= BSC_IDLE;
      seq_cnt_q  <= 16'h0000;
      comm_cnt_q <= 8'h00;
    end else if (!enable_q) begin
      // Clearing enable returns to idle from any state
      state_q    <= BSC_IDLE;
      seq_cnt_q  <= 16'h0000;
      comm_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        BSC_IDLE: begin
          if (init_done) begin
            state_q <= BSC_ALIGN;                                 // R1
          end
        end
        BSC_ALIGN: begin
          if (seq_cnt_q == align_len_q) begin
            state_q   <= BSC_OPEN;                                // R3
            seq_cnt_q <= 16'h0000;
          end else begin
            seq_cnt_q <= seq_cnt_q + 16'h0001;
          end
        end
        BSC_OPEN: begin
          if (ol_comm_hit) begin
            seq_cnt_q  <= 16'h0000;
            comm_cnt_q <= comm_cnt_q + 8'h01;
            if (comm_cnt_q + 8'h01 >= open_cnt_q) begin
              state_q <= BSC_RUN;                                 // R5
            end
          end else begin
            seq_cnt_q <= seq_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= BSC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sector <= BSC_SECTOR_RST;
    end else if (state_q != BSC_OPEN && state_q != BSC_RUN) begin
      // Idle and alignment preload the start sector for open loop
      sector <= BSC_SECTOR_START;                                 // R4
    end else if (comm_ev) begin
      sector <= sector_inc(sector);                               // R24
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      commutate    <= 1'b0;
      run_state    <= 2'h0;
      align_drive  <= 1'b0;
      align_duty_a <= 16'h0000;
      align_duty_b <= 16'h0000;
      align_duty_c <= 16'h0000;
    end else begin
      commutate    <= comm_ev;                                    // R21
      run_state    <= state_q;
      align_drive  <= (state_q == BSC_ALIGN);
      align_duty_a <= (state_q == BSC_ALIGN) ? duty_q : 16'h0000; // R2
      align_duty_b <= (state_q == BSC_ALIGN) ? duty_q : 16'h0000; // R2
      align_duty_c <= 16'h0000;                                   // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timestamps and blanking
  logic [15:0] ts_q, ts_bak_q, blank_q;
  // Old stamp kept so the sample period tracks the PWM rate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ts_q     <= 16'h0000;
      ts_bak_q <= 16'h0000;
    end else if (trigger_done) begin
      ts_bak_q <= ts_q;                                           // R6
      ts_q     <= timer_value;                                    // R6
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blank_q <= 16'h0000;
    end else if (comm_ev) begin
      // Zero means the transient after commutation has died out
      blank_q <= blank_len_q;                                     // R24
    end else if (blank_q != 16'h0000) begin
      blank_q <= blank_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossing detection
  logic        a0_seen_q, a1_seen_q, both_done;
  logic [BSC_VW-1:0] ph_q, bus_q;
  logic signed [BSC_VW+1:0] bemf, bemf_dir, prev_q, delta;
  logic        falling, eval;
  logic [15:0] per, zc_time, zc_old_q, zc_new_q, raw_per;
  logic [31:0] prod;
  logic [15:0] offs;

  // Lists may finish in either order; wait for both
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      a0_seen_q <= 1'b0;
      a1_seen_q <= 1'b0;
      ph_q      <= '0;
      bus_q     <= '0;
    end else begin
      // A list end in the clearing cycle wins, else it would be lost
      if (adc0_done) begin
        a0_seen_q <= 1'b1;
        bus_q     <= bus_voltage;
      end else if (both_done) begin
        a0_seen_q <= 1'b0;
      end
      if (adc1_done) begin
        a1_seen_q <= 1'b1;
        ph_q      <= phase_voltage;
      end else if (both_done) begin
        a1_seen_q <= 1'b0;
      end
    end
  end
  assign both_done = a0_seen_q & a1_seen_q;                       // R7

  assign bemf = $signed({2'b00, ph_q})
              - $signed({3'b000, bus_q[BSC_VW-1:1]});             // R8
  // Odd sectors see a falling back-EMF on the floating phase
  assign falling  = sector[0];                                    // R11 R15
  assign bemf_dir = falling ? -bemf : bemf;                       // R23
  assign delta    = bemf_dir - (falling ? -prev_q : prev_q);
  assign eval     = both_done && (blank_q == 16'h0000)            // R9
                    && !found_q && (state_q == BSC_RUN);          // R10
  assign per      = ts_q - ts_bak_q;
  // Division is kept combinational; fine at this sample rate
  assign prod     = 32'(unsigned'(bemf_dir[BSC_VW:0])) * 32'(per);
  assign offs     = (delta > 0) ?
                    16'(prod / 32'(unsigned'(delta[BSC_VW:0]))) : 16'h0000;
  assign zc_time  = ts_q - offs;                                  // R17
  assign raw_per  = zc_time - zc_new_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_q <= '0;
    end else if (both_done) begin
      prev_q <= bemf;                                             // R12
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      found_q     <= 1'b0;
      zc_old_q    <= 16'h0000;
      zc_new_q    <= 16'h0000;
      zc_per_q    <= 16'h0000;
      next_comm_q <= 16'h0000;
    end else if (eval && bemf_dir > 0) begin                      // R16
      // Set wins over a commutation clear in the same cycle
      zc_old_q    <= zc_new_q;                                    // R18
      zc_new_q    <= zc_time;                                     // R18
      // Quarter-weight filter: one noisy crossing barely moves it
      zc_per_q    <= zc_per_q - (zc_per_q >> BSC_FILT_SHIFT)
                     + (raw_per >> BSC_FILT_SHIFT);               // R18
      next_comm_q <= zc_time + (zc_per_q >> 1) - adv_q;           // R19
      found_q     <= 1'b1;                                        // R20
    end else if (comm_ev) begin
      found_q <= 1'b0;                                            // R24
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_mux <= 2'h0;
      glb_ldok  <= 1'b0;
    end else begin
      glb_ldok <= 1'b0;
      if (eval && bemf_dir > 0) begin
        phase_mux <= float_phase(sector_inc(sector));             // R13
        glb_ldok  <= 1'b1;                                        // R14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond speed tick
  logic [31:0] tick_cnt_q;
  // 32 bits cover any tick period a sane clock would need

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 32'h0;
      speed_tick <= 1'b0;
    end else if (tick_cnt_q == TICK_CYC - 1) begin
      tick_cnt_q <= 32'h0;
      speed_tick <= 1'b1;                                         // R22
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      speed_tick <= 1'b0;
    end
  end
endmodule // bsc_seq

/* File: bsc_seq_chk.sv */
// Port checker for the commutation sequencer
`timescale 1ns/100ps
module bsc_seq_chk import bsc_pkg::*; #(
  parameter int unsigned TICK_CYC = BSC_TICK_CYC
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  sector,
  input wire logic        glb_ldok,
  input wire logic        commutate,
  input wire logic        speed_tick,
  input wire logic [1:0]  run_state,
  input wire logic        align_drive,
  input wire logic [15:0] align_duty_a,
  input wire logic [15:0] align_duty_b,
  input wire logic [15:0] align_duty_c
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] gap_q;
  logic        seen_q;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last tick; the first tick has no reference
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (speed_tick) begin
      gap_q  <= 32'h1;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_tick_period: assert property (
    speed_tick && seen_q |-> gap_q == TICK_CYC)
    else $error("speed tick spacing wrong");
  a_phase_c_low: assert property (align_drive |-> align_duty_c == 16'h0)
    else $error("phase c driven during alignment");
  a_duty_ab_same: assert property (
    align_drive |-> align_duty_a == align_duty_b)
    else $error("phase a and b duties differ");
  a_align_state: assert property (
    align_drive && $past(align_drive) |-> run_state == 2'h1)
    else $error("alignment drive outside alignment");
  a_sector_range: assert property (sector <= BSC_SECTOR_LAST)
    else $error("sector out of range");
  a_sector_step: assert property ($changed(sector) |->
    sector == (($past(sector) == BSC_SECTOR_LAST) ? 3'h0
               : $past(sector) + 3'h1))
    else $error("sector did not advance modulo six");
  a_ldok_pulse: assert property (glb_ldok |=> !glb_ldok)
    else $error("load ok longer than one cycle");
  a_comm_pulse: assert property (commutate |=> !commutate)
    else $error("commutation pulse too long");
  a_no_open_eval: assert property (run_state != 2'h3 |-> !glb_ldok)
    else $error("crossing evaluated outside run");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule // bsc_seq_chk

bind bsc_seq bsc_seq_chk #(.TICK_CYC(TICK_CYC)) i_chk (.clk, .reset, .avs_read,
  .avs_write, .avs_waitrequest, .sector, .glb_ldok, .commutate, .speed_tick,
  .run_state, .align_drive, .align_duty_a, .align_duty_b, .align_duty_c);

/* File: bsc_stage.sv */
// Power stage and converter path model feeding the sequencer
`timescale 1ns/100ps
module bsc_stage import bsc_pkg::*; #(
  parameter int PER = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             commutate,
  input  wire logic [2:0]       sector,
  output logic [BSC_TW-1:0]     timer_value,
  output logic                  trigger_done,
  output logic                  adc0_done,
  output logic                  adc1_done,
  output logic [BSC_VW-1:0]     phase_voltage,
  output logic [BSC_VW-1:0]     bus_voltage
);
  logic [7:0]        cnt_q;
  logic [BSC_VW-1:0] ramp_q;
  logic [BSC_VW-1:0] v;
  // Back-EMF restarts at each commutation; odd sectors fall
  assign v = sector[0] ? 12'h500 - ramp_q : 12'h300 + ramp_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_value <= '0;
      cnt_q       <= 8'h0;
      ramp_q      <= 12'h0;
    end else begin
      timer_value <= timer_value + 16'h1;
      cnt_q       <= (cnt_q == 8'(PER - 1)) ? 8'h0 : cnt_q + 8'h1;
      if (commutate) ramp_q <= 12'h0;
      else if (cnt_q == 8'h0 && ramp_q < 12'h300) ramp_q <= ramp_q + 12'h20;
    end
  end
  // Samples valid only with their list-end pulse; otherwise inverted
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trigger_done  <= 1'b0;
      adc0_done     <= 1'b0;
      adc1_done     <= 1'b0;
      phase_voltage <= 12'h0;
      bus_voltage   <= 12'h0;
    end else begin
      trigger_done  <= cnt_q == 8'h0;
      adc1_done     <= cnt_q == 8'h3;
      adc0_done     <= cnt_q == 8'h5;
      phase_voltage <= (cnt_q == 8'h3) ? v : ~v;
      bus_voltage   <= (cnt_q == 8'h5) ? 12'h800 : 12'h7ff;
    end
  end
endmodule // bsc_stage

/* File: tb_bsc_seq.sv */
// Register-level testbench for the commutation sequencer
`timescale 1ns/100ps
module tb_bsc_seq;
  import bsc_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [5:0]        avs_address = 6'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              init_done = 1'b0;
  logic [BSC_TW-1:0] timer_value;
  logic              trigger_done, adc0_done, adc1_done;
  logic [BSC_VW-1:0] phase_voltage, bus_voltage;
  logic [2:0]        sector;
  logic [1:0]        phase_mux, run_state;
  logic              glb_ldok, commutate, speed_tick, align_drive;
  logic [15:0]       align_duty_a, align_duty_b, align_duty_c;
  logic [31:0]       rd;
  logic [2:0]        s0;
  int                err_total = 0;
  int                tests_run = 0;
  int                n;
  always #2.5 clk = ~clk;
  bsc_seq #(.TICK_CYC(50)) i_dut (.clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .init_done,
    .timer_value, .trigger_done, .adc0_done, .adc1_done, .phase_voltage,
    .bus_voltage, .sector, .phase_mux, .glb_ldok, .commutate, .speed_tick,
    .run_state, .align_drive, .align_duty_a, .align_duty_b, .align_duty_c);
  bsc_stage i_stage (.clk, .reset, .commutate, .sector, .timer_value,
    .trigger_done, .adc0_done, .adc1_done, .phase_voltage, .bus_voltage);
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_total++;
    stop_test;
  endtask
  // Hold the request until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) hang;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (s !== 1'b1 && k < lim);
    if (k >= lim) hang;
  endtask
  task automatic wait_state(input logic [1:0] st, input int lim);
    int k;
    k = 0;
    while (run_state !== st && k < lim) begin
      @(negedge clk);
      if (commutate === 1'b1) n++;
      k++;
    end
    if (k >= lim) hang;
  endtask
  function automatic logic [1:0] mux_of(input logic [2:0] s);
    return (s == 3'h0 || s == 3'h3) ? 2'h2
         : (s == 3'h1 || s == 3'h4) ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [2:0] nxt(input logic [2:0] s);
    return (s == BSC_SECTOR_LAST) ? 3'h0 : s + 3'h1;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(32'(run_state), 32'h0);
    bus(1'b0, BSC_REG_STATUS, 32'h0);
    chk(rd, {25'h0, BSC_SECTOR_START, 4'h0});
    bus(1'b1, 6'h3c, 32'h5a5a);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, BSC_REG_ALIGN, 32'h40);
    bus(1'b1, BSC_REG_OPEN, 32'h3);
    bus(1'b1, BSC_REG_BLANK, 32'h40);
    bus(1'b1, BSC_REG_ADV, 32'h0);
    bus(1'b1, BSC_REG_DUTY, 32'h123);
    bus(1'b1, BSC_REG_OLPER, 32'h80);
    bus(1'b1, BSC_REG_CTRL, 32'h1);
    bus(1'b0, BSC_REG_DUTY, 32'h0);
    chk(rd, 32'h123);
    $display("test registers done");
    init_done <= 1'b1;
    wait_state(2'h1, 20);
    @(negedge clk);
    chk(32'(align_drive), 32'h1);
    chk(32'(align_duty_a), 32'h123);
    chk(32'(align_duty_b), 32'h123);
    chk(32'(align_duty_c), 32'h0);
    wait_state(2'h2, 100);
    chk(32'(sector), 32'(BSC_SECTOR_START));
    $display("test alignment done");
    n = 0;
    wait_state(2'h3, 2000);
    chk(n, 3);
    $display("test open loop done");
    wait_hi(glb_ldok, 4000);
    chk(32'(phase_mux), 32'(mux_of(nxt(sector))));
    s0 = sector;
    bus(1'b0, BSC_REG_STATUS, 32'h0);
    chk(32'(rd[7]), 32'h1);
    wait_hi(commutate, 70000);
    @(negedge clk);
    chk(32'(sector), 32'(nxt(s0)));
    bus(1'b0, BSC_REG_STATUS, 32'h0);
    chk(32'(rd[7]), 32'h0);
    wait_hi(speed_tick, 100);
    $display("test run done");
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(32'(run_state), 32'h0);
    chk(32'(commutate), 32'h0);
    bus(1'b0, BSC_REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    stop_test;
  end
endmodule // tb_bsc_seq
